// >>> design/hbm_master.sv
/*
 * multiplexed address/data host bus master: runs read, write and
 * wait-for-pin commands against an external peripheral chip.
 * assumes a same-clock command source; bus pins are asynchronous and are
 * resynchronised; the testbench resolves the shared data wire from oe.
 */
// Functional notes
// - extended access drives high address first
// - upper address on its own pins
// - one clock address setup before latch strobe
// - latch pulse one clock, two when waiting
// - write: latch fall with chip select low
// - write data one clock before write strobe
// - write strobe six clocks when waiting
// - select off half clock after strobe
// - read select phase three clocks when waiting
// - read select falls one clock after latch
// - read: release bus, assert read strobe together
// - read strobe one clock, five when waiting
// - read end: select off, bus driven again
// - command stalls until watched pin level
`timescale 1ns/1ps
module hbm_master (
	// clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// command port
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire hbm_pkg::hbm_op_t cmd_op_in,
	input wire logic cmd_ext_in,
	input wire logic [hbm_pkg::ADDR_W-1:0] cmd_addr_in,
	input wire logic [hbm_pkg::DATA_W-1:0] cmd_wdata_in,
	input wire logic cmd_level_in,
	// response port
	output logic rsp_valid_out,
	output logic [hbm_pkg::DATA_W-1:0] rsp_rdata_out,
	// multiplexed address/data pins
	input wire logic [hbm_pkg::DATA_W-1:0] muxed_addr_data_in,
	output logic [hbm_pkg::DATA_W-1:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe_out,
	// address and strobes
	output logic [hbm_pkg::DATA_W-1:0] upper_address_out,
	output logic ale_out,
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic bus_clock_out,
	// peripheral status pins
	input wire logic wait_ready_in,
	input wire logic irq_wait_pin_in
);
	import hbm_pkg::*;

	hbm_state_t state_r;
	hbm_state_t state_nxt;
	hbm_op_t op_r;
	logic ext_r;
	logic level_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic [PH_CNT_W-1:0] cnt_r;
	logic [DATA_W-1:0] ad_meta_r;
	logic [DATA_W-1:0] ad_sync_r;
	logic wait_meta_r;
	logic wait_sync_r;
	logic irq_meta_r;
	logic irq_sync_r;
	logic rise_tick;
	logic fall_tick;
	logic step;
	logic half;
	logic wait_lo;
	logic take;
	logic pin_hit;
	logic entering;

	// true when a phase of the given stretched length has run its course
	function automatic logic phase_done(input logic [PH_CNT_W-1:0] cnt,
		input logic [PH_CNT_W-1:0] long_len, input logic lo);
		logic [PH_CNT_W-1:0] len;
		len = lo ? long_len : PH_ONE;
		phase_done = (cnt >= (len - PH_ONE));
	endfunction

	hbm_clkgen u_clkgen (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.bus_clock_out(bus_clock_out),
		.rise_tick_out(rise_tick),
		.fall_tick_out(fall_tick)
	);

	// two-stage synchronisers for pins from the peripheral
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ad_meta_r <= AD_RST;
			ad_sync_r <= AD_RST;
			wait_meta_r <= 1'b1;
			wait_sync_r <= 1'b1;
			irq_meta_r <= 1'b0;
			irq_sync_r <= 1'b0;
		end else if (ce_in) begin
			ad_meta_r <= muxed_addr_data_in;
			ad_sync_r <= ad_meta_r;
			wait_meta_r <= wait_ready_in;
			wait_sync_r <= wait_meta_r;
			irq_meta_r <= irq_wait_pin_in;
			irq_sync_r <= irq_meta_r;
		end
	end

	// phase timing strobes
	assign step = ce_in && rise_tick;
	assign half = ce_in && fall_tick;
	assign wait_lo = !wait_sync_r;
	assign cmd_ready_out = (state_r == ST_IDLE);
	assign take = ce_in && cmd_valid_in && cmd_ready_out;
	assign pin_hit = (irq_sync_r == level_r);
	assign entering = (state_nxt != state_r);

	// next state of the bus cycle
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take) begin
					if (cmd_op_in == OP_WAIT_PIN) begin
						state_nxt = ST_WAIT_PIN;
					end else if (cmd_op_in == OP_NONE) begin
						state_nxt = ST_FINISH;
					end else begin
						state_nxt = ST_ARM;
					end
				end
			end
			ST_ARM: begin
				if (step) begin
					// non-extended access skips the high byte
					state_nxt = ext_r ? ST_HIGH_ADDR : ST_LOW_ADDR;
				end
			end
			ST_HIGH_ADDR: begin
				if (step) begin
					state_nxt = ST_LOW_ADDR;
				end
			end
			ST_LOW_ADDR: begin
				if (step) begin
					state_nxt = ST_ALE_HI;
				end
			end
			ST_ALE_HI: begin
				if (step && phase_done(cnt_r, ALE_LONG, wait_lo)) begin
					state_nxt = (op_r == OP_WRITE) ? ST_WR_SETUP : ST_RD_CS;
				end
			end
			ST_WR_SETUP: begin
				if (step) begin
					state_nxt = ST_WR_LOW;
				end
			end
			ST_WR_LOW: begin
				if (step && phase_done(cnt_r, WR_LONG, wait_lo)) begin
					state_nxt = ST_FINISH;
				end
			end
			ST_RD_CS: begin
				if (step && phase_done(cnt_r, RD_CS_LONG, wait_lo)) begin
					state_nxt = ST_RD_LOW;
				end
			end
			ST_RD_LOW: begin
				if (step && phase_done(cnt_r, RD_LONG, wait_lo)) begin
					state_nxt = ST_FINISH;
				end
			end
			ST_FINISH: begin
				// closing half clock, taken on the bus clock fall
				if (half || op_r == OP_NONE) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_WAIT_PIN: begin
				if (ce_in && pin_hit) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// state and phase counter
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ST_IDLE;
			cnt_r <= PH_CNT_RST;
		end else if (ce_in) begin
			state_r <= state_nxt;
			if (entering) begin
				cnt_r <= PH_CNT_RST;
			end else if (step) begin
				cnt_r <= cnt_r + PH_ONE;
			end
		end
	end

	// command capture
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			op_r <= OP_READ;
			ext_r <= 1'b0;
			level_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= AD_RST;
		end else if (take) begin
			op_r <= cmd_op_in;
			ext_r <= cmd_ext_in;
			level_r <= cmd_level_in;
			addr_r <= cmd_addr_in;
			wdata_r <= cmd_wdata_in;
		end
	end

	// upper address pins, held until the next extended access
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			upper_address_out <= AD_RST;
		end else if (ce_in && entering && state_nxt == ST_HIGH_ADDR) begin
			upper_address_out <= addr_r[ADDR_HI_LSB +: DATA_W];
		end
	end

	// multiplexed bus drive and direction
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			muxed_addr_data_out <= AD_RST;
			muxed_addr_data_oe_out <= 1'b1;
		end else if (ce_in && entering) begin
			if (state_nxt == ST_LOW_ADDR) begin
				muxed_addr_data_out <= addr_r[DATA_W-1:0];
			end
			if (state_nxt == ST_WR_SETUP) begin
				muxed_addr_data_out <= wdata_r;
			end
			// release the bus together with the read strobe
			if (state_nxt == ST_RD_LOW) begin
				muxed_addr_data_oe_out <= 1'b0;
			end
			// write data held and bus driven again at the half clock
			if (state_nxt == ST_IDLE && state_r == ST_FINISH) begin
				muxed_addr_data_oe_out <= 1'b1;
			end
		end
	end

	// address latch strobe
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ale_out <= 1'b0;
		end else if (ce_in && entering) begin
			ale_out <= (state_nxt == ST_ALE_HI);
		end
	end

	// chip select
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cs_n_out <= 1'b1;
		end else if (ce_in) begin
			if (state_r == ST_FINISH && state_nxt == ST_IDLE) begin
				cs_n_out <= 1'b1;
			end else if (entering && state_nxt == ST_WR_SETUP) begin
				cs_n_out <= 1'b0;
			end else if (step && state_r == ST_ALE_HI && cnt_r == PH_CNT_RST &&
				op_r == OP_READ) begin
				// one clock after the latch rose, stretched or not
				cs_n_out <= 1'b0;
			end
		end
	end

	// read and write strobes
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_n_out <= 1'b1;
			wr_n_out <= 1'b1;
		end else if (ce_in && entering) begin
			rd_n_out <= !(state_nxt == ST_RD_LOW);
			wr_n_out <= !(state_nxt == ST_WR_LOW);
		end
	end

	// response and read data capture
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= AD_RST;
		end else if (ce_in) begin
			rsp_valid_out <= entering && state_nxt == ST_IDLE;
			if (state_r == ST_RD_LOW && state_nxt == ST_FINISH) begin
				// peripheral still drives while both strobes are low
				rsp_rdata_out <= ad_sync_r;
			end
		end
	end
endmodule

// >>> design/hbm_pkg.sv
/*
 * shared constants, states and command codes of the host bus master.
 * assumes a 50 mhz system clock; bus phases count bus clock periods, the closing phase a half period.
 */
package hbm_pkg;
	// system and bus clock timing
	localparam int SYS_PERIOD_NS = 20;
	localparam int BUS_HALF_NS = 40;
	localparam int BUS_HALF_CYC_RAW =
		(BUS_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int BUS_HALF_CYC = (BUS_HALF_CYC_RAW < 1) ? 1 :
		BUS_HALF_CYC_RAW;
	localparam int HALF_CNT_W = 4;
	localparam logic [HALF_CNT_W-1:0] HALF_CNT_MAX =
		HALF_CNT_W'(BUS_HALF_CYC - 1);
	localparam logic [HALF_CNT_W-1:0] HALF_CNT_RST = 4'h0;

	// bus widths and field positions
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int ADDR_HI_LSB = 8;
	localparam logic [DATA_W-1:0] AD_RST = 8'h00;

	// phase lengths in bus clocks, short and stretched by wait
	localparam int PH_CNT_W = 3;
	localparam logic [PH_CNT_W-1:0] PH_CNT_RST = 3'h0;
	localparam logic [PH_CNT_W-1:0] PH_ONE = 3'h1;
	localparam logic [PH_CNT_W-1:0] ALE_LONG = 3'h2;
	localparam logic [PH_CNT_W-1:0] WR_LONG = 3'h6;
	localparam logic [PH_CNT_W-1:0] RD_CS_LONG = 3'h3;
	localparam logic [PH_CNT_W-1:0] RD_LONG = 3'h5;

	// command codes
	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_WAIT_PIN = 2'b10,
		OP_NONE = 2'b11
	} hbm_op_t;

	// bus cycle states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ARM = 4'h1,
		ST_HIGH_ADDR = 4'h2,
		ST_LOW_ADDR = 4'h3,
		ST_ALE_HI = 4'h4,
		ST_WR_SETUP = 4'h5,
		ST_WR_LOW = 4'h6,
		ST_RD_CS = 4'h7,
		ST_RD_LOW = 4'h8,
		ST_FINISH = 4'h9,
		ST_WAIT_PIN = 4'ha
	} hbm_state_t;
endpackage

// >>> design/hbm_clkgen.sv
/*
 * bus clock divider: makes the bus clock pin and one-cycle tick pulses
 * marking its rising and falling edges.
 * assumes the system clock and a clock enable that freezes the divider.
 */
`timescale 1ns/1ps
module hbm_clkgen (
	// clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// bus clock and edge ticks
	output logic bus_clock_out,
	output logic rise_tick_out,
	output logic fall_tick_out
);
	import hbm_pkg::*;

	logic [HALF_CNT_W-1:0] cnt_r;
	logic wrap;

	assign wrap = ce_in && (cnt_r == HALF_CNT_MAX);
	// ticks coincide with the pin toggle, so logic moves with the edge
	assign rise_tick_out = wrap && !bus_clock_out;
	assign fall_tick_out = wrap && bus_clock_out;

	// half period counter and pin toggle
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= HALF_CNT_RST;
			bus_clock_out <= 1'b0;
		end else if (ce_in) begin
			if (wrap) begin
				cnt_r <= HALF_CNT_RST;
				bus_clock_out <= !bus_clock_out;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule

// >>> bench/hbm_master_props.sv
/* timing checker for the host bus master pins.
   assumes ce_in is held high while traffic runs. */
`timescale 1ns/1ps
module hbm_chk (
	// clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// command port
	input wire logic cmd_valid_in,
	input wire logic cmd_ready_out,
	input wire hbm_pkg::hbm_op_t cmd_op_in,
	input wire logic cmd_ext_in,
	input wire logic [hbm_pkg::ADDR_W-1:0] cmd_addr_in,
	input wire logic [hbm_pkg::DATA_W-1:0] cmd_wdata_in,
	// bus pins
	input wire logic [hbm_pkg::DATA_W-1:0] muxed_addr_data_out,
	input wire logic muxed_addr_data_oe_out,
	input wire logic [hbm_pkg::DATA_W-1:0] upper_address_out,
	input wire logic ale_out,
	input wire logic cs_n_out,
	input wire logic rd_n_out,
	input wire logic wr_n_out
);
	import hbm_pkg::*;
	logic rd_r;
	logic ext_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wd_r;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// fields of the command being run
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_r <= 1'b0;
			ext_r <= 1'b0;
			addr_r <= 16'h0000;
			wd_r <= 8'h00;
		end else if (ce_in && cmd_valid_in && cmd_ready_out) begin
			rd_r <= (cmd_op_in == OP_READ);
			ext_r <= cmd_ext_in;
			addr_r <= cmd_addr_in;
			wd_r <= cmd_wdata_in;
		end
	end
	a_upper_addr: assert property ($rose(ale_out) && ext_r |->
		upper_address_out == addr_r[15:8]) else $error("upper address");
	a_addr_setup: assert property ($rose(ale_out) |->
		$past(muxed_addr_data_out, 3) == addr_r[7:0]) else $error("setup");
	a_ale_width: assert property ($rose(ale_out) |->
		ale_out [*4] ##[1:5] !ale_out) else $error("latch width");
	a_wr_cs_ale: assert property ($fell(ale_out) && !rd_r |->
		$fell(cs_n_out)) else $error("write select");
	a_wdata_setup: assert property ($fell(wr_n_out) |->
		$past(muxed_addr_data_out, 4) == wd_r) else $error("data setup");
	a_wr_width: assert property ($fell(wr_n_out) |->
		!wr_n_out [*4] ##[1:21] wr_n_out) else $error("write width");
	a_wdata_hold: assert property (!cs_n_out && !rd_r && !ale_out |->
		muxed_addr_data_oe_out && muxed_addr_data_out == wd_r)
		else $error("data hold");
	a_cs_half: assert property ($rose(rd_n_out) || $rose(wr_n_out) |->
		!cs_n_out ##1 !cs_n_out ##1 cs_n_out) else $error("select end");
	a_rd_cs_delay: assert property ($rose(ale_out) && rd_r |->
		##4 $fell(cs_n_out)) else $error("read select");
	a_rd_release: assert property ($fell(rd_n_out) |->
		$fell(muxed_addr_data_oe_out)) else $error("bus release");
	a_rd_width: assert property ($fell(rd_n_out) |->
		!rd_n_out [*4] ##[1:17] rd_n_out) else $error("read width");
	a_oe_back: assert property ($rose(cs_n_out) |->
		muxed_addr_data_oe_out) else $error("bus drive");
endmodule
bind hbm_master hbm_chk chk (.*);

// >>> bench/hbm_periph.sv
/* peripheral model on the multiplexed bus.
   assumes pull-ups on the shared lines, resolved by the bench. */
`timescale 1ns/1ps
module hbm_periph (
	// pins seen by the peripheral
	input wire logic [7:0] bus_in,
	input wire logic ale_in,
	input wire logic cs_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	// bench asks for a slow answer
	input wire logic slow_in,
	// pins driven back
	output logic wait_ready_out,
	output logic drive_out,
	output logic [7:0] data_out
);
	logic [7:0] mem [256];
	logic [7:0] lat_r;
	logic [7:0] adr_q;
	// slow peripheral stretches the latch, read select and strobe phases
	assign wait_ready_out = !slow_in;
	// address copied while stable at strobe rise, since write data
	// replaces it on the lines in the same step as the strobe falls
	always @(posedge ale_in) adr_q = bus_in;
	// low address latched at strobe fall
	always @(negedge ale_in) lat_r = adr_q;
	// write stored at strobe rise
	always @(posedge wr_n_in) if (!cs_n_in) mem[lat_r] = bus_in;
	// drive only while selected and reading
	assign drive_out = !cs_n_in && !rd_n_in;
	assign data_out = mem[lat_r];
endmodule

// >>> bench/tb_hbm_master.sv
/* self-checking bench for the host bus master.
   assumes a peripheral model on the far side of the pins. */
`timescale 1ns/1ps
module tb_hbm_master;
	import hbm_pkg::*;
	logic clk_sys_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1;
	logic cmd_valid_in = 1'b0, cmd_ext_in = 1'b0, cmd_level_in = 1'b0;
	hbm_op_t cmd_op_in = OP_NONE;
	logic [15:0] cmd_addr_in = 16'h0000;
	logic [7:0] cmd_wdata_in = 8'h00;
	logic irq_wait_pin_in = 1'b0, slow = 1'b0, cmd_ready_out, rsp_valid_out;
	logic [7:0] rsp_rdata_out, muxed_addr_data_out, upper_address_out, pd;
	logic muxed_addr_data_oe_out, ale_out, cs_n_out, rd_n_out, wr_n_out;
	logic bus_clock_out, wait_ready_in, pdrv;
	wire logic [7:0] muxed_addr_data_in;
	int failures = 0, num_checks = 0, c_al, c_wr, c_rd, c_cs;
	int l_al, l_wr, l_rd, l_cs;
	time t_done, t_up;
	// shared lines: pull-up when nobody drives
	assign muxed_addr_data_in = muxed_addr_data_oe_out ?
		muxed_addr_data_out : (pdrv ? pd : 8'hff);
	hbm_master uut (.*);
	hbm_periph peer (.bus_in(muxed_addr_data_in), .ale_in(ale_out),
		.cs_n_in(cs_n_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
		.slow_in(slow), .wait_ready_out(wait_ready_in),
		.drive_out(pdrv), .data_out(pd));
	always #10 clk_sys_in = ~clk_sys_in;
	// strobe widths in system cycles
	always @(posedge clk_sys_in) begin
		c_al <= ale_out ? c_al + 1 : 0;
		c_wr <= !wr_n_out ? c_wr + 1 : 0;
		c_rd <= !rd_n_out ? c_rd + 1 : 0;
		c_cs <= (!cs_n_out && rd_n_out) ? c_cs + 1 : 0;
		if (!ale_out && c_al != 0) l_al <= c_al;
		if (wr_n_out && c_wr != 0) l_wr <= c_wr;
		if (rd_n_out && c_rd != 0) l_rd <= c_rd;
		if (!rd_n_out && c_cs != 0) l_cs <= c_cs;
	end
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// one command, held until taken, then wait for the answer
	task automatic cmd(input hbm_op_t op, input logic ext,
		input logic [15:0] a, input logic [7:0] d, input logic lv);
		int n;
		@(negedge clk_sys_in);
		cmd_valid_in = 1'b1;
		cmd_op_in = op;
		cmd_ext_in = ext;
		cmd_addr_in = a;
		cmd_wdata_in = d;
		cmd_level_in = lv;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (cmd_ready_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			end_of_test();
		end
		@(negedge clk_sys_in);
		cmd_valid_in = 1'b0;
		while (rsp_valid_out !== 1'b1 && n < 500) begin
			@(posedge clk_sys_in);
			n++;
		end
		t_done = $time;
		if (n >= 500) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic t_fast();
		logic [3:0] bc;
		// bus clock: two cycles high, two low
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_sys_in);
			bc[i] = bus_clock_out;
		end
		check(bc === 4'h3 || bc === 4'h6 || bc === 4'hc || bc === 4'h9,
			"bus clock");
		cmd(OP_WRITE, 1'b1, 16'h12a5, 8'h3c, 1'b0);
		check(upper_address_out === 8'h12, "upper");
		check(l_al === 4 && l_wr === 4, "fast write widths");
		cmd(OP_READ, 1'b0, 16'h77a5, 8'h00, 1'b0);
		check(rsp_rdata_out === 8'h3c, "read data");
		check(upper_address_out === 8'h12, "upper moved");
		check(l_rd === 4 && l_cs === 4, "fast read widths");
		cmd(OP_WRITE, 1'b0, 16'h00c3, 8'h5a, 1'b0);
		cmd(OP_READ, 1'b1, 16'h9ec3, 8'h00, 1'b0);
		check(rsp_rdata_out === 8'h5a && upper_address_out === 8'h9e,
			"ext read");
		$display("fast cycles done");
	endtask
	task automatic t_slow();
		@(negedge clk_sys_in);
		slow = 1'b1;
		cmd(OP_WRITE, 1'b0, 16'h0011, 8'h96, 1'b0);
		check(l_al === 8 && l_wr === 24, "slow write widths");
		cmd(OP_READ, 1'b0, 16'h0011, 8'h00, 1'b0);
		check(rsp_rdata_out === 8'h96 && l_rd === 20, "slow read");
		check(l_cs >= 12 && l_cs <= 16, "slow select phase");
		@(negedge clk_sys_in);
		slow = 1'b0;
		$display("slow cycles done");
	endtask
	task automatic t_pin();
		for (int lv = 1; lv >= 0; lv--) begin
			@(negedge clk_sys_in);
			irq_wait_pin_in = !lv[0];
			fork
				cmd(OP_WAIT_PIN, 1'b0, 16'h0000, 8'h00, lv[0]);
				begin
					repeat (40) @(negedge clk_sys_in);
					t_up = $time;
					irq_wait_pin_in = lv[0];
				end
			join
			check(t_done > t_up && t_done < t_up + 200, "pin wait");
		end
		$display("pin wait done");
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_in);
		check(cs_n_out === 1'b1 && ale_out === 1'b0 && rd_n_out === 1'b1
			&& wr_n_out === 1'b1 && cmd_ready_out === 1'b1, "reset");
		@(negedge clk_sys_in);
		resetn_in = 1'b1;
		t_fast();
		t_slow();
		t_pin();
		end_of_test();
	end
endmodule
